// *** hw/wofd_detector.sv ***
`timescale 1ns/1ns
`default_nettype none
module wofd_detector
    import wofd_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       por,
    input  wire logic       wdt_osc_clk,
    input  wire logic       primary_fail_in,
    input  wire logic       ctl_wr,
    input  wire logic [7:0] ctl_wdata,
    output var  logic [7:0] ctl_rdata,
    output var  logic       wdt_fail_nmi,
    output var  logic       wdt_failed,
    output var  logic       primary_fail_nmi,
    output var  logic [1:0] clk_select,
    output var  logic       device_halted
);
    logic [7:0]            ctl_reg;
    logic [7:0]            ctl_next;
    wofd_lock_t            lock_reg;
    wofd_lock_t            lock_next;
    logic [WOFD_CNT_W-1:0] cnt_reg;
    logic [WOFD_CNT_W-1:0] cnt_next;
    logic                  failed_reg;
    logic                  nmi_reg;
    logic                  pnmi_reg;
    logic                  halt_reg;
    logic                  pfail_s1_reg;
    logic                  pfail_s2_reg;
    logic                  wdt_edge;
    logic                  wdt_fail_detect_enable;
    logic                  primary_fail_detect_enable;
    logic                  all_off;
    logic                  timeout_hit;
    logic                  write_ok;
    logic [1:0]            sel_field;
    logic                  wdt_unusable;

    wofd_edge_sync u_sync
    (
        .sys_clk    (sys_clk),
        .reset      (reset),
        .async_in   (wdt_osc_clk),
        .edge_pulse (wdt_edge)
    );

    assign wdt_fail_detect_enable     = ctl_reg[WOFD_BIT_WFD_EN];
    assign primary_fail_detect_enable = ctl_reg[WOFD_BIT_PFD_EN];
    assign sel_field                  = ctl_reg[WOFD_SEL_LSB +: 2];
    // Detector blind when watchdog clock is selected or stopped
    assign wdt_unusable = !ctl_reg[WOFD_BIT_WDT_EN] || (sel_field == WOFD_SEL_WDT);
    // Unlock sequence then one write opens and relocks
    assign write_ok  = ctl_wr && (lock_reg == WOFD_OPEN);
    assign ctl_next  = write_ok ? ctl_wdata : ctl_reg;
    always_comb
    begin
        lock_next = lock_reg;
        if (ctl_wr)
        begin
            case (lock_reg)
                WOFD_LOCKED: lock_next = (ctl_wdata == WOFD_UNLOCK_1) ? WOFD_HALF : WOFD_LOCKED;
                WOFD_HALF:   lock_next = (ctl_wdata == WOFD_UNLOCK_2) ? WOFD_OPEN : WOFD_LOCKED;
                WOFD_OPEN:   lock_next = WOFD_LOCKED;
                default:     lock_next = WOFD_LOCKED;
            endcase
        end
    end
    // Count system clocks, restart on watchdog edge or when disabled
    assign timeout_hit = (cnt_reg == WOFD_TIMEOUT_CNT - WOFD_CNT_ONE) && !wdt_edge;
    assign cnt_next    = (!wdt_fail_detect_enable || wdt_edge || failed_reg) ? WOFD_CNT_ZERO
                       : cnt_reg + WOFD_CNT_ONE;
    // Primary, watchdog and external sources and both detections disabled (crystal has no enable bit)
    assign all_off = !ctl_reg[WOFD_BIT_PRI_EN] && !ctl_reg[WOFD_BIT_WDT_EN]
                   && !ctl_reg[WOFD_BIT_EXT_EN] && !wdt_fail_detect_enable
                   && !primary_fail_detect_enable;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            ctl_reg      <= WOFD_CTL_RESET;
            lock_reg     <= WOFD_LOCKED;
            cnt_reg      <= WOFD_CNT_ZERO;
            failed_reg   <= 1'b0;
            nmi_reg      <= 1'b0;
            pnmi_reg     <= 1'b0;
            pfail_s1_reg <= 1'b0;
            pfail_s2_reg <= 1'b0;
        end
        else
        begin
            if (!halt_reg)
            begin
                ctl_reg  <= ctl_next;
                lock_reg <= lock_next;
            end
            cnt_reg      <= cnt_next;
            pfail_s1_reg <= primary_fail_in;
            pfail_s2_reg <= pfail_s1_reg;
            // Sticky failure, one-cycle alert
            nmi_reg      <= wdt_fail_detect_enable && !failed_reg && timeout_hit;
            if (wdt_fail_detect_enable && timeout_hit)
                failed_reg <= 1'b1;
            // Primary detection blocked once watchdog failed
            pnmi_reg     <= pfail_s2_reg && primary_fail_detect_enable && !failed_reg;
        end
    end
    // Only power-on reset leaves the halted state
    always_ff @(posedge sys_clk)
    begin
        if (por)
            halt_reg <= 1'b0;
        else if (all_off)
            halt_reg <= 1'b1;
    end
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            ctl_rdata  <= WOFD_CTL_RESET;
            clk_select <= WOFD_SEL_PRIMARY;
        end
        else
        begin
            ctl_rdata  <= ctl_reg;
            // Selection follows software only, never the failure
            clk_select <= sel_field;
        end
    end
    assign wdt_fail_nmi     = nmi_reg;
    assign wdt_failed       = failed_reg;
    assign primary_fail_nmi = pnmi_reg;
    assign device_halted    = halt_reg;

    a_fail_after_timeout: assert property (@(posedge sys_clk) disable iff (reset)
        (wdt_fail_detect_enable && !failed_reg && timeout_hit) |=> wdt_fail_nmi)
        else $error("missing alert at timeout");
    a_no_early_fail: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(failed_reg) |-> $past(cnt_reg) == WOFD_TIMEOUT_CNT - WOFD_CNT_ONE)
        else $error("failure declared early");
    a_alert_once: assert property (@(posedge sys_clk) disable iff (reset)
        wdt_fail_nmi |=> !wdt_fail_nmi)
        else $error("alert longer than one cycle");
    a_edge_restart: assert property (@(posedge sys_clk) disable iff (reset)
        wdt_edge |=> cnt_reg == WOFD_CNT_ZERO)
        else $error("counter not restarted");
    a_select_kept: assert property (@(posedge sys_clk) disable iff (reset)
        ($rose(failed_reg) && $stable(ctl_reg)) |=> $stable(clk_select))
        else $error("clock select moved on failure");
    a_primary_blocked: assert property (@(posedge sys_clk) disable iff (reset)
        failed_reg |=> !primary_fail_nmi)
        else $error("primary alert after watchdog failure");
    a_locked_write: assert property (@(posedge sys_clk) disable iff (reset)
        (ctl_wr && lock_reg != WOFD_OPEN) |=> ctl_reg == $past(ctl_reg))
        else $error("write accepted while locked");
    a_relock: assert property (@(posedge sys_clk) disable iff (reset)
        write_ok && !halt_reg |=> lock_reg == WOFD_LOCKED ##1 ctl_rdata == $past(ctl_reg))
        else $error("no relock after write");
    a_halt_sticky: assert property (@(posedge sys_clk)
        (halt_reg && !por) |=> halt_reg)
        else $error("halt left without power-on reset");
    a_disabled_idle: assert property (@(posedge sys_clk) disable iff (reset)
        !wdt_fail_detect_enable |=> cnt_reg == WOFD_CNT_ZERO)
        else $error("counter runs while disabled");
    c_fail: cover property (@(posedge sys_clk) disable iff (reset) wdt_fail_nmi);
    c_unlock: cover property (@(posedge sys_clk) disable iff (reset) write_ok);
    c_halt: cover property (@(posedge sys_clk) $rose(halt_reg));
    c_pfail: cover property (@(posedge sys_clk) disable iff (reset) primary_fail_nmi);
    c_blind: cover property (@(posedge sys_clk) disable iff (reset)
        wdt_unusable && wdt_fail_detect_enable);
    a_fail_sticky: assert property (@(posedge sys_clk) disable iff (reset)
        failed_reg |=> failed_reg)
        else $error("failure flag dropped");
    a_count_step: assert property (@(posedge sys_clk) disable iff (reset)
        (wdt_fail_detect_enable && !wdt_edge && !failed_reg) |=> cnt_reg == $past(cnt_reg) + WOFD_CNT_ONE)
        else $error("counter did not advance");
    a_no_alert_off: assert property (@(posedge sys_clk) disable iff (reset)
        !wdt_fail_detect_enable |=> !wdt_fail_nmi)
        else $error("alert while detection disabled");
    a_pfail_pass: assert property (@(posedge sys_clk) disable iff (reset)
        (pfail_s2_reg && primary_fail_detect_enable && !failed_reg) |=> primary_fail_nmi)
        else $error("primary alert missing");
    a_pfail_idle: assert property (@(posedge sys_clk) disable iff (reset)
        !pfail_s2_reg |=> !primary_fail_nmi)
        else $error("primary alert without failure");
    a_halt_entry: assert property (@(posedge sys_clk)
        (all_off && !por) |=> device_halted)
        else $error("no halt with everything disabled");
    a_halt_clear: assert property (@(posedge sys_clk)
        por |=> !device_halted)
        else $error("power-on reset did not clear halt");
    a_halt_freeze: assert property (@(posedge sys_clk) disable iff (reset)
        halt_reg |=> ctl_reg == $past(ctl_reg))
        else $error("control changed while halted");
    a_key_first: assert property (@(posedge sys_clk) disable iff (reset)
        (ctl_wr && !halt_reg && lock_reg == WOFD_LOCKED && ctl_wdata == WOFD_UNLOCK_1)
        |=> lock_reg == WOFD_HALF)
        else $error("first key not taken");
    a_key_second: assert property (@(posedge sys_clk) disable iff (reset)
        (ctl_wr && !halt_reg && lock_reg == WOFD_HALF && ctl_wdata == WOFD_UNLOCK_2)
        |=> lock_reg == WOFD_OPEN)
        else $error("second key not taken");
    a_key_wrong: assert property (@(posedge sys_clk) disable iff (reset)
        (ctl_wr && !halt_reg && lock_reg == WOFD_HALF && ctl_wdata != WOFD_UNLOCK_2)
        |=> lock_reg == WOFD_LOCKED)
        else $error("wrong key did not relock");
    a_write_lands: assert property (@(posedge sys_clk) disable iff (reset)
        (write_ok && !halt_reg) |=> ctl_reg == $past(ctl_wdata))
        else $error("unlocked write lost");
    a_rdata_follow: assert property (@(posedge sys_clk) disable iff (reset)
        1'b1 |=> ctl_rdata == $past(ctl_reg))
        else $error("read copy out of step");
endmodule
`default_nettype wire

// *** hw/wofd_pkg.sv ***
`default_nettype none
package wofd_pkg;
    // Oscillator select codes
    localparam logic [1:0] WOFD_SEL_PRIMARY  = 2'h0;
    localparam logic [1:0] WOFD_SEL_WDT      = 2'h1;
    localparam logic [1:0] WOFD_SEL_EXTERNAL = 2'h2;
    localparam logic [1:0] WOFD_SEL_CRYSTAL  = 2'h3;
    // Control register fields
    localparam int         WOFD_BIT_PRI_EN   = 7;
    localparam int         WOFD_BIT_WDT_EN   = 6;
    localparam int         WOFD_BIT_EXT_EN   = 5;
    localparam int         WOFD_BIT_PFD_EN   = 4;
    localparam int         WOFD_BIT_WFD_EN   = 3;
    localparam int         WOFD_SEL_LSB      = 0;
    localparam logic [7:0] WOFD_CTL_RESET    = 8'hA0;
    // Unlock sequence
    localparam logic [7:0] WOFD_UNLOCK_1     = 8'hE7;
    localparam logic [7:0] WOFD_UNLOCK_2     = 8'h18;
    // Failure timeout in system clock cycles
    localparam int         WOFD_TIMEOUT      = 8004;
    localparam int         WOFD_CNT_W        = 13;
    localparam logic [WOFD_CNT_W-1:0] WOFD_TIMEOUT_CNT = WOFD_CNT_W'(WOFD_TIMEOUT);
    localparam logic [WOFD_CNT_W-1:0] WOFD_CNT_ZERO    = 13'h0000;
    localparam logic [WOFD_CNT_W-1:0] WOFD_CNT_ONE     = 13'h0001;
    typedef enum logic [1:0] {WOFD_LOCKED, WOFD_HALF, WOFD_OPEN} wofd_lock_t;
endpackage
`default_nettype wire

// *** hw/wofd_edge_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module wofd_edge_sync
(
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic async_in,
    output var  logic edge_pulse
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    // Two-stage synchroniser then rising edge detect
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end
        else
        begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end
    assign edge_pulse = sync2_reg & ~prev_reg;
endmodule
`default_nettype wire

// *** verif/wofd_cpu_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module wofd_cpu_model
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       wdt_fail_nmi,
    input  wire logic       primary_fail_nmi,
    output var  logic [3:0] nmi_count,
    output var  logic       pri_seen
);
    // Counts each watchdog alert pulse as one non-maskable event; a primary alert only sets pri_seen
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            nmi_count <= 4'h0;
            pri_seen  <= 1'b0;
        end
        else
        begin
            nmi_count <= nmi_count + {3'h0, wdt_fail_nmi};
            pri_seen  <= pri_seen | primary_fail_nmi;
        end
    end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module testbench;
    import wofd_pkg::*;
    logic       sys_clk = 1'b0, reset = 1'b1, por = 1'b1, wdt_osc_clk = 1'b0;
    logic       primary_fail_in = 1'b0, ctl_wr = 1'b0, wdt_run = 1'b0;
    logic [7:0] ctl_wdata = 8'h00, ctl_rdata;
    logic       wdt_fail_nmi, wdt_failed, primary_fail_nmi, device_halted, pri_seen;
    logic [1:0] clk_select, div = 2'h0;
    logic [3:0] nmi_count;
    int         err_count = 0, tests_run = 0, cyc = 0;
    wofd_detector i_wofd_detector (.sys_clk(sys_clk), .reset(reset), .por(por),
        .wdt_osc_clk(wdt_osc_clk), .primary_fail_in(primary_fail_in), .ctl_wr(ctl_wr),
        .ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .wdt_fail_nmi(wdt_fail_nmi),
        .wdt_failed(wdt_failed), .primary_fail_nmi(primary_fail_nmi),
        .clk_select(clk_select), .device_halted(device_halted));
    wofd_cpu_model i_wofd_cpu_model (.sys_clk(sys_clk), .reset(reset),
        .wdt_fail_nmi(wdt_fail_nmi), .primary_fail_nmi(primary_fail_nmi),
        .nmi_count(nmi_count), .pri_seen(pri_seen));
    always #5 sys_clk = ~sys_clk;
    // Watchdog oscillator runs at a sixth of the system clock
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (wdt_run)
            div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
        if (wdt_run && div == 2'h2)
            wdt_osc_clk <= ~wdt_osc_clk;
        if (cyc == 40000)
        begin
            err_count++;
            close_out();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge sys_clk);
        ctl_wr    <= 1'b1;
        ctl_wdata <= d;
    endtask
    task automatic put(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] d);
        wr(k1);
        wr(k2);
        wr(d);
        @(posedge sys_clk);
        ctl_wr <= 1'b0;
        step(3);
    endtask
    task automatic t_reset_and_lock();
        `CHK(ctl_rdata, WOFD_CTL_RESET)
        `CHK(clk_select, WOFD_SEL_PRIMARY)
        put(8'h00, 8'h00, 8'hE1); // Locked: ignored
        `CHK(ctl_rdata, WOFD_CTL_RESET)
        put(WOFD_UNLOCK_1, 8'h81, 8'hE1); // Wrong second key
        `CHK(ctl_rdata, WOFD_CTL_RESET)
        put(WOFD_UNLOCK_1, WOFD_UNLOCK_2, 8'hE2);
        `CHK(ctl_rdata, 8'hE2)
        `CHK(clk_select, WOFD_SEL_EXTERNAL)
        put(8'hE2, 8'hE2, 8'hE3); // Relocked after the write
        `CHK(ctl_rdata, 8'hE2)
    endtask
    task automatic t_detect_off();
        put(WOFD_UNLOCK_1, WOFD_UNLOCK_2, 8'hD0);
        step(8100);
        `CHK(wdt_failed, 1'b0)
    endtask
    task automatic t_failure();
        wdt_run <= 1'b1;
        put(WOFD_UNLOCK_1, WOFD_UNLOCK_2, 8'hDB);
        primary_fail_in <= 1'b1;
        step(200);
        `CHK(primary_fail_nmi, 1'b1)
        `CHK(pri_seen, 1'b1)
        primary_fail_in <= 1'b0;
        step(8000);
        `CHK(wdt_failed, 1'b0)
        `CHK(nmi_count, 4'h0)
        // Stop after a rising edge; sync and edge detect add two cycles
        @(posedge wdt_osc_clk);
        wdt_run <= 1'b0;
        step(WOFD_TIMEOUT + 2);
        `CHK(wdt_failed, 1'b0)
        `CHK(wdt_fail_nmi, 1'b0)
        step(1);
        `CHK(wdt_failed, 1'b1)
        `CHK(wdt_fail_nmi, 1'b1)
        step(1);
        `CHK(wdt_fail_nmi, 1'b0)
        `CHK(nmi_count, 4'h1)
        `CHK(clk_select, WOFD_SEL_CRYSTAL)
        primary_fail_in <= 1'b1;
        step(10);
        `CHK(primary_fail_nmi, 1'b0)
        primary_fail_in <= 1'b0;
    endtask
    task automatic t_halt();
        put(WOFD_UNLOCK_1, WOFD_UNLOCK_2, 8'h00);
        `CHK(device_halted, 1'b1)
        reset <= 1'b1;
        step(2);
        reset <= 1'b0;
        step(2);
        `CHK(device_halted, 1'b1)
        `CHK(wdt_failed, 1'b0)
        por <= 1'b1;
        step(2);
        por <= 1'b0;
        step(2);
        `CHK(device_halted, 1'b0)
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        step(4);
        reset <= 1'b0;
        por   <= 1'b0;
        step(2);
        t_reset_and_lock();
        t_detect_off();
        t_failure();
        t_halt();
        close_out();
    end
endmodule
`default_nettype wire
